// ===== hw/fpm_host.sv
/*
  Host controller for a boot-block flash: drives reset/power-down,
  write-protect and supply-enable pins and sequences commands.
  Assumes flash pins synchronous to clk and one request at a time.
*/
`timescale 1ns/100ps
module fpm_host
  import fpm_pkg::*;
#(
  parameter int PD_EXIT = FPM_PD_EXIT_CYC,
  parameter int STROBE  = FPM_STROBE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // User side
  input  wire logic        req_valid,
  output logic             req_ready,
  input  fpm_req_t         req,
  output logic             rsp_valid,
  output fpm_rsp_t         rsp,
  input  wire logic        powerdown_req,
  input  wire logic        unlock_boot,
  input  wire logic        boot_hv_unlock,
  input  wire logic        prog_supply_on,
  input  wire logic        boot_addr_hit,
  // Flash pins
  output logic             reset_powerdown_pin,
  output logic             high_voltage_level,
  output logic             write_protect_n,
  output logic             prog_supply_en,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [17:0]      a,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i
);

  //==========================================================================
  // Sequencer
  typedef enum logic [3:0] {
    FPM_S_PD      = 4'b0000,
    FPM_S_WAKE    = 4'b0001,
    FPM_S_IDLE    = 4'b0010,
    FPM_S_CMD1    = 4'b0011,
    FPM_S_CMD2    = 4'b0100,
    FPM_S_POLLC   = 4'b0101,
    FPM_S_POLL    = 4'b0110,
    FPM_S_ARRAY   = 4'b0111,
    FPM_S_READ    = 4'b1000,
    FPM_S_RESP    = 4'b1001
  } fpm_state_t;

  fpm_state_t           st_r, st_nxt;
  fpm_req_t             req_r;
  logic [FPM_CNT_W-1:0] wake_r;
  logic [15:0]          sr_r;
  logic                 refused_r;
  logic                 go, wr, done;
  logic [17:0]          cyc_addr;
  logic [15:0]          cyc_data, rdata;

  fpm_bus_cycle #(.STROBE(STROBE)) u_cyc (
    .clk   (clk),
    .rst   (rst),
    .go    (go),
    .wr    (wr),
    .addr  (cyc_addr),
    .wdata (cyc_data),
    .done  (done),
    .rdata (rdata),
    .ce_n  (ce_n),
    .oe_n  (oe_n),
    .we_n  (we_n),
    .a     (a),
    .dq_o  (dq_o),
    .dq_oe (dq_oe),
    .dq_i  (dq_i)
  );

  function automatic logic is_write_op(input fpm_op_t op);
    is_write_op = (op == FPM_OP_PROG) || (op == FPM_OP_ERASE);
  endfunction

  // Boot block writable only with write-protect high or high voltage
  wire boot_ok   = unlock_boot || boot_hv_unlock;
  // Refuse locally a write with supply off or to a locked block flagged by boot_addr_hit, saving a wasted cycle
  wire refuse    = is_write_op(req_r.op) &&
                   (!prog_supply_on || (boot_addr_hit && !boot_ok));
  wire wake_done = (wake_r == FPM_CNT_W'(PD_EXIT - 1));
  // rdata only updates on the edge that ends a cycle, so a decision taken
  // on that same edge has to look at the pins or it sees the previous word
  wire [15:0] poll_word = dq_i;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FPM_S_PD:    if (!powerdown_req) st_nxt = FPM_S_WAKE;
      FPM_S_WAKE:  if (wake_done) st_nxt = FPM_S_IDLE;
      FPM_S_IDLE: begin
        if (powerdown_req) st_nxt = FPM_S_PD;
        else if (req_valid) st_nxt = FPM_S_CMD1;
      end
      FPM_S_CMD1: begin
        if (refuse) st_nxt = FPM_S_RESP;
        else if (done) st_nxt = (req_r.op == FPM_OP_READ) ? FPM_S_READ :
                                is_write_op(req_r.op) ? FPM_S_CMD2 :
                                (req_r.op == FPM_OP_STATUS) ? FPM_S_POLL : FPM_S_RESP;
      end
      FPM_S_CMD2:  if (done) st_nxt = FPM_S_POLLC;
      FPM_S_POLLC: if (done) st_nxt = FPM_S_POLL;
      FPM_S_POLL: begin
        if (done) begin
          if (req_r.op == FPM_OP_STATUS) st_nxt = FPM_S_RESP;
          else if (poll_word[FPM_SR_READY]) st_nxt = FPM_S_ARRAY;
        end
      end
      FPM_S_ARRAY: if (done) st_nxt = FPM_S_RESP;
      FPM_S_READ:  if (done) st_nxt = FPM_S_RESP;
      FPM_S_RESP:  st_nxt = FPM_S_IDLE;
      default:     st_nxt = FPM_S_PD;
    endcase
  end

  // Bus cycle selection per state
  wire cmd1_wr  = (req_r.op != FPM_OP_READ);
  wire [7:0] cmd1_code = (req_r.op == FPM_OP_PROG)   ? FPM_CMD_PROG_SETUP  :
                         (req_r.op == FPM_OP_ERASE)  ? FPM_CMD_ERASE_SETUP :
                         (req_r.op == FPM_OP_STATUS) ? FPM_CMD_READ_STATUS :
                         (req_r.op == FPM_OP_CLEAR)  ? FPM_CMD_CLR_STATUS  :
                                                       FPM_CMD_READ_ARRAY;
  wire [15:0] cmd2_data = (req_r.op == FPM_OP_ERASE) ? {8'h00, FPM_CMD_ERASE_CONF}
                                                     : req_r.data;
  assign go = ((st_r == FPM_S_CMD1) && !refuse) || (st_r == FPM_S_CMD2) ||
              (st_r == FPM_S_POLLC) || (st_r == FPM_S_POLL) ||
              (st_r == FPM_S_ARRAY) || (st_r == FPM_S_READ);
  assign wr = ((st_r == FPM_S_CMD1) && cmd1_wr) || (st_r == FPM_S_CMD2) ||
              (st_r == FPM_S_POLLC) || (st_r == FPM_S_ARRAY);
  // A plain read reuses CMD1 as its access; READ then re-reads the held data
  assign cyc_addr = req_r.addr;
  assign cyc_data = (st_r == FPM_S_CMD2)  ? cmd2_data :
                    (st_r == FPM_S_POLLC) ? {8'h00, FPM_CMD_READ_STATUS} :
                    (st_r == FPM_S_ARRAY) ? {8'h00, FPM_CMD_READ_ARRAY} :
                                            {8'h00, cmd1_code};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= FPM_S_PD;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_r <= '0;
    end else if ((st_r == FPM_S_IDLE) && req_valid && !powerdown_req) begin
      req_r <= req;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_r <= '0;
    end else if (st_r == FPM_S_WAKE) begin
      wake_r <= wake_r + 1'b1;
    end else begin
      wake_r <= '0;
    end
  end

  // Status copy dies with the reset pin, as the device's own does
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_r      <= '0;
      refused_r <= 1'b0;
    end else if (st_r == FPM_S_PD) begin
      sr_r      <= '0;
      refused_r <= 1'b0;
    end else if ((st_r == FPM_S_POLL) && done) begin
      sr_r      <= poll_word;
    end else if ((st_r == FPM_S_CMD1) && refuse) begin
      refused_r <= 1'b1;
    end else if (st_r == FPM_S_IDLE) begin
      refused_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else if (st_r == FPM_S_RESP) begin
      rsp.data <= is_write_op(req_r.op) || (req_r.op == FPM_OP_STATUS) ? sr_r : rdata;
      rsp.err  <= refused_r || sr_r[FPM_SR_VPP_E] || sr_r[FPM_SR_PROG_E] ||
                  sr_r[FPM_SR_ERASE_E];
      rsp.boot_refused <= refused_r;
    end
  end

  //==========================================================================
  // Pin levels
  // Reset pin held low through controller reset and power-down
  assign reset_powerdown_pin = (st_r != FPM_S_PD);
  assign high_voltage_level  = boot_hv_unlock && reset_powerdown_pin;
  assign write_protect_n     = unlock_boot;
  assign prog_supply_en      = prog_supply_on;
  assign req_ready           = (st_r == FPM_S_IDLE) && !powerdown_req;
  assign rsp_valid           = (st_r == FPM_S_RESP);

  a_wake_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(reset_powerdown_pin) |-> (st_r == FPM_S_WAKE) [*8])
    else $error("request path opened before wake time");
  a_cs_in_pd: assert property (@(posedge clk) disable iff (rst)
    (st_r == FPM_S_PD) |-> ce_n && !dq_oe)
    else $error("bus driven in power-down");
  a_prog_two: assert property (@(posedge clk) disable iff (rst)
    (st_r == FPM_S_CMD2) && done |=> (st_r == FPM_S_POLLC))
    else $error("second step not followed by poll");
  a_refuse_lock: assert property (@(posedge clk) disable iff (rst)
    (st_r == FPM_S_CMD1) && refuse |-> !go ##1 rsp_valid)
    else $error("locked write reached the bus");
  a_sr_clear: assert property (@(posedge clk) disable iff (rst)
    !reset_powerdown_pin |=> (sr_r == 16'h0000))
    else $error("status copy kept across power-down");

endmodule // fpm_host

// ===== hw/fpm_pkg.sv
/*
  Package for the boot-block flash host controller: command codes,
  status bit positions, timing constants and user-side carrier structs.
  Assumes a single 125 MHz clock and a parallel flash with strobes.
*/
// Notes on behaviour
// - Host waits power-down exit access time before trusting read data.
// - After program or erase host issues read-array before array reads.
// - Read-array command byte is ff, returning reads to array data.
// - After power-up host drops chip-select or new address before trusting data.
// - Reset pin follows system reset so array data returns after reset.
package fpm_pkg;

  //==========================================================================
  // Command codes
  localparam logic [7:0] FPM_CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] FPM_CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] FPM_CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0] FPM_CMD_PROG_SETUP  = 8'h40;
  localparam logic [7:0] FPM_CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] FPM_CMD_ERASE_CONF  = 8'hd0;

  //==========================================================================
  // Status bit positions
  localparam int FPM_SR_READY   = 7;
  localparam int FPM_SR_ERASE_E = 5;
  localparam int FPM_SR_PROG_E  = 4;
  localparam int FPM_SR_VPP_E   = 3;

  //==========================================================================
  // Timing (ns) and derived cycle counts at 125 MHz
  localparam int FPM_CLK_NS       = 8;
  localparam int FPM_STROBE_NS    = 60;   // least strobe / access phase
  localparam int FPM_PD_EXIT_NS   = 600;  // powerdown_exit_access_time default
  localparam int FPM_STROBE_CYC   = (FPM_STROBE_NS + FPM_CLK_NS - 1) / FPM_CLK_NS;
  localparam int FPM_PD_EXIT_CYC  = (FPM_PD_EXIT_NS + FPM_CLK_NS - 1) / FPM_CLK_NS;
  localparam int FPM_CNT_W        = 8;

  //==========================================================================
  // User request kinds
  typedef enum logic [2:0] {
    FPM_OP_READ   = 3'b000,
    FPM_OP_STATUS = 3'b001,
    FPM_OP_PROG   = 3'b010,
    FPM_OP_ERASE  = 3'b011,
    FPM_OP_CLEAR  = 3'b100,
    FPM_OP_ARRAY  = 3'b101
  } fpm_op_t;

  typedef struct packed {
    fpm_op_t     op;
    logic [17:0] addr;
    logic [15:0] data;
  } fpm_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic        err;
    logic        boot_refused;
  } fpm_rsp_t;

endpackage

// ===== hw/fpm_bus_cycle.sv
/*
  One bus cycle on the flash pins: a read or a write, each held for a
  fixed strobe width. Assumes flash pins synchronous to clk.
*/
`timescale 1ns/100ps
module fpm_bus_cycle
  import fpm_pkg::*;
#(
  parameter int STROBE = FPM_STROBE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Cycle request
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // Flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [17:0]      a,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i
);

  logic [FPM_CNT_W-1:0] cnt_r;
  logic                 busy_r;
  logic                 wr_r;
  wire                  last = busy_r && (cnt_r == FPM_CNT_W'(STROBE - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
      wr_r   <= 1'b0;
      a      <= '0;
      dq_o   <= '0;
      rdata  <= '0;
    end else if (!busy_r && go) begin
      busy_r <= 1'b1;
      cnt_r  <= '0;
      wr_r   <= wr;
      a      <= addr;
      dq_o   <= wdata;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 1'b1;
      if (last) begin
        busy_r <= 1'b0;
        rdata  <= dq_i;
      end
    end
  end

  assign done  = last;
  // Both strobes low together is the only write the flash accepts
  assign ce_n  = !busy_r;
  assign we_n  = !(busy_r && wr_r);
  assign oe_n  = !(busy_r && !wr_r);
  assign dq_oe = busy_r && wr_r;

  a_strobe_pair: assert property (@(posedge clk) disable iff (rst)
    !we_n |-> !ce_n && !oe_n == 1'b0)
    else $error("write strobe without chip select");

endmodule // fpm_bus_cycle

// ===== verification/fpm_flash_model.sv
/*
  Behavioural boot-block flash: pins, command interface, locks, status.
  Assumes strobes change only on clk edges; word index {a[17],a[2:0]}.
*/
`timescale 1ns/100ps
module fpm_flash_model
  import fpm_pkg::*;
#(
  parameter int BUSY = 20
) (
  // Clock
  input  wire logic        clk,
  // Flash pins
  input  wire logic        reset_powerdown_pin,
  input  wire logic        high_voltage_level,
  input  wire logic        write_protect_n,
  input  wire logic        prog_supply_en,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [17:0] a,
  input  wire logic [15:0] din,
  output logic      [15:0] dq
);
  logic [15:0] mem [16];
  logic [15:0] cnt, wd;
  logic [17:0] wa;
  logic [2:0]  se;
  logic [1:0]  pend;
  logic [7:0]  bsy;
  logic        st_mode, we_q, ce_q;
  // Take a write on the rising write strobe, chip-select low in the cycle before
  wire wr_ev = reset_powerdown_pin && we_n && !we_q && !ce_q;
  wire lock  = !prog_supply_en || (wa[17] && !write_protect_n && !high_voltage_level);
  wire drv   = reset_powerdown_pin && !ce_n && !oe_n;
  wire [7:0] sr = {bsy == 8'h00, 1'b0, se, 3'b000};
  assign dq = drv ? (st_mode ? {8'h00, sr} : mem[{a[17], a[2:0]}]) : cnt;

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    cnt = 16'h0000;
  end

  //==========================================================================
  // Command interface
  always @(posedge clk) begin
    cnt  <= cnt + 16'h5a3b;
    we_q <= we_n;
    ce_q <= ce_n;
    if (!we_n && !ce_n) begin
      wa <= a;
      wd <= din;
    end
    if (!reset_powerdown_pin) begin
      if (bsy != 8'h00) mem[{wa[17], wa[2:0]}] <= 16'h0bad;
      se <= 3'b000;
      st_mode <= 1'b0;
      pend <= 2'd0;
      bsy <= 8'h00;
    end else begin
      if (bsy != 8'h00) bsy <= bsy - 8'h01;
      if (wr_ev && pend != 2'd0) begin
        pend <= 2'd0;
        st_mode <= 1'b1;
        bsy <= 8'(BUSY);
        if (lock) se <= se | {pend == 2'd2, pend == 2'd1, !prog_supply_en};
        else if (pend == 2'd1) mem[{wa[17], wa[2:0]}] <= mem[{wa[17], wa[2:0]}] & wd;
        else if (wd[7:0] == FPM_CMD_ERASE_CONF)
          for (int i = 0; i < 8; i++) mem[{wa[17], 3'(i)}] <= 16'hffff;
      end else if (wr_ev) begin
        case (wd[7:0])
          FPM_CMD_PROG_SETUP:  pend <= (bsy == 8'h00) ? 2'd1 : 2'd0;
          FPM_CMD_ERASE_SETUP: pend <= (bsy == 8'h00) ? 2'd2 : 2'd0;
          FPM_CMD_READ_STATUS: st_mode <= 1'b1;
          FPM_CMD_CLR_STATUS:  se <= 3'b000;
          FPM_CMD_READ_ARRAY:  st_mode <= 1'b0;
          default: ;
        endcase
      end
    end
  end
endmodule // fpm_flash_model

// ===== verification/test_flash_protect_power_modes.sv
/*
  Self-checking bench for the flash host controller with a flash model.
  Assumes the controller and model share clk; inputs move on falling edges.
*/
`timescale 1ns/100ps
module test_flash_protect_power_modes;
  import fpm_pkg::*;
  localparam int PDX = 8;
  logic clk, rst, req_valid, req_ready, rsp_valid, pd, unl, hv, sup, hit;
  logic rp, hvl, wp_n, sup_en, ce_n, oe_n, we_n, dq_oe;
  logic [17:0] a;
  logic [15:0] dq_o, m_dq;
  fpm_req_t req;
  fpm_rsp_t rsp;
  int checked, n_fail;
  // The wire level: controller drives during writes, else the model
  wire [15:0] bus = dq_oe ? dq_o : m_dq;

  fpm_host #(.PD_EXIT(PDX), .STROBE(2)) i_dut (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp(rsp), .powerdown_req(pd), .unlock_boot(unl), .boot_hv_unlock(hv),
    .prog_supply_on(sup), .boot_addr_hit(hit), .reset_powerdown_pin(rp),
    .high_voltage_level(hvl), .write_protect_n(wp_n), .prog_supply_en(sup_en),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a(a), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(bus));
  fpm_flash_model i_flash (.clk(clk), .reset_powerdown_pin(rp),
    .high_voltage_level(hvl), .write_protect_n(wp_n), .prog_supply_en(sup_en),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a(a), .din(bus), .dq(m_dq));

  //==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input fpm_op_t o, input logic [17:0] ad, input logic [15:0] d);
    int n;
    n = 0;
    req = '{op: o, addr: ad, data: d};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 500) begin @(negedge clk); n++; end
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    @(negedge clk);
    if (n >= 2000) chk(16'hdead, 16'h0000);
  endtask

  task automatic complete_run();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  //==========================================================================
  // Scenarios
  task automatic t_prog();
    op(FPM_OP_PROG, 18'h00003, 16'h1234);
    chk({14'h0, rsp.err, rsp.boot_refused}, 16'h0000);
    chk(rsp.data, 16'h0080);
    op(FPM_OP_READ, 18'h00003, 16'h0000);
    chk(rsp.data, 16'h1234);
    op(FPM_OP_READ, 18'h00004, 16'h0000);
    chk(rsp.data, 16'hffff);
    op(FPM_OP_STATUS, 18'h00000, 16'h0000);
    chk(rsp.data, 16'h0080);
    op(FPM_OP_ARRAY, 18'h00000, 16'h0000);
    op(FPM_OP_READ, 18'h00003, 16'h0000);
    chk(rsp.data, 16'h1234);
    $display("test prog done");
  endtask

  task automatic t_lock();
    hit = 1'b1;
    for (int i = 0; i < 4; i++) begin
      unl = i[1];
      hv = i[0];
      @(negedge clk);
      chk({14'h0, wp_n, hvl}, 16'(i));
      op(FPM_OP_PROG, 18'h20000 + 18'(i), 16'h4321);
      chk({14'h0, rsp.err, rsp.boot_refused}, (i == 0) ? 16'h0003 : 16'h0000);
      op(FPM_OP_READ, 18'h20000 + 18'(i), 16'h0000);
      chk(rsp.data, (i == 0) ? 16'hffff : 16'h4321);
    end
    op(FPM_OP_ERASE, 18'h20000, 16'h0000);
    op(FPM_OP_READ, 18'h20002, 16'h0000);
    chk(rsp.data, 16'hffff);
    unl = 1'b0;
    hv = 1'b0;
    hit = 1'b0;
    $display("test lock done");
  endtask

  task automatic t_supply();
    sup = 1'b0;
    @(negedge clk);
    chk({15'h0, sup_en}, 16'h0000);
    op(FPM_OP_PROG, 18'h00005, 16'h0000);
    chk({15'h0, rsp.err}, 16'h0001);
    op(FPM_OP_ERASE, 18'h00000, 16'h0000);
    chk({15'h0, rsp.err}, 16'h0001);
    sup = 1'b1;
    op(FPM_OP_READ, 18'h00005, 16'h0000);
    chk(rsp.data, 16'hffff);
    $display("test supply done");
  endtask

  task automatic t_pd();
    int n;
    n = 0;
    op(FPM_OP_PROG, 18'h20005, 16'h0000);
    chk({14'h0, rsp.err, rsp.boot_refused}, 16'h0002);
    chk(rsp.data, 16'h0090);
    op(FPM_OP_STATUS, 18'h00000, 16'h0000);
    chk(rsp.data, 16'h0090);
    pd = 1'b1;
    while (rp !== 1'b0 && n < 20) begin @(negedge clk); n++; end
    repeat (3) @(negedge clk);
    chk({13'h0, rp, ce_n, dq_oe}, 16'h0002);
    chk({15'h0, req_ready}, 16'h0000);
    pd = 1'b0;
    n = 0;
    while (rp !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin @(negedge clk); n++; end
    chk(16'(n), 16'(PDX));
    op(FPM_OP_READ, 18'h00003, 16'h0000);
    chk(rsp.data, 16'h1234);
    op(FPM_OP_READ, 18'h20005, 16'h0000);
    chk(rsp.data, 16'hffff);
    op(FPM_OP_STATUS, 18'h00000, 16'h0000);
    chk(rsp.data, 16'h0080);
    op(FPM_OP_PROG, 18'h20005, 16'h0000);
    op(FPM_OP_CLEAR, 18'h00000, 16'h0000);
    op(FPM_OP_STATUS, 18'h00000, 16'h0000);
    chk(rsp.data, 16'h0080);
    $display("test powerdown done");
  endtask

  //==========================================================================
  // Clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #400000;
    n_fail++;
    complete_run();
  end

  initial begin
    checked = 0;
    n_fail = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    pd = 1'b0;
    unl = 1'b0;
    hv = 1'b0;
    sup = 1'b1;
    hit = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_prog();
    t_lock();
    t_supply();
    t_pd();
    complete_run();
  end
endmodule // test_flash_protect_power_modes
